// [hdl/cbr_pkg.sv]
package cbr_pkg;

  // widths
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int BANK_W = 2;
  localparam int WREG_W = 3;
  localparam int LEN_W = 2;
  localparam int RAM_DEPTH_DEF = 256;
  localparam int RAM_RD_PORTS = 3;

  // read port numbering of the internal ram
  localparam int RP_BUS = 0;
  localparam int RP_WREG = 1;
  localparam int RP_POP = 2;

  // register port map
  localparam logic [7:0] DIRECT_RAM_TOP = 8'h7F;
  localparam logic [7:0] OFS_ACC = 8'h80;
  localparam logic [7:0] OFS_AUX = 8'h81;
  localparam logic [7:0] OFS_SP = 8'h82;
  localparam logic [7:0] OFS_DP0_LO = 8'h83;
  localparam logic [7:0] OFS_DP0_HI = 8'h84;
  localparam logic [7:0] OFS_DP1_LO = 8'h85;
  localparam logic [7:0] OFS_DP1_HI = 8'h86;
  localparam logic [7:0] OFS_PTR_SEL = 8'h87;
  localparam logic [7:0] OFS_BANK_SEL = 8'h88;

  // field positions
  localparam int PTR_SEL_BIT = 0;
  localparam int BANK_LSB = 0;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] DPTR_RST = 16'h0000;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic PTR_SEL_RST = 1'b0;
  localparam logic [7:0] RAM_RST = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage

// [hdl/cbr_iram.sv]
`timescale 1ns/10ps
`default_nettype none
module cbr_iram
  import cbr_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH_DEF,
  parameter int RD_PORTS = RAM_RD_PORTS
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [BYTE_W-1:0] waddr_in,
  input wire logic [BYTE_W-1:0] wdata_in,
  input wire logic [RD_PORTS-1:0] re_in,
  input wire logic [RD_PORTS*BYTE_W-1:0] raddr_in,
  output logic [RD_PORTS*BYTE_W-1:0] rdata_out
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 32 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cbr_iram: DEPTH must be a power of two from 32 to 256");
  end
  if (RD_PORTS < 1) begin : g_bad_ports
    $error("cbr_iram: RD_PORTS must be at least 1");
  end

  logic [BYTE_W-1:0] mem_ff [DEPTH];

  // addresses above DEPTH alias onto the low bytes
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        mem_ff[i] <= RAM_RST;
      end else if (ce_in && we_in && waddr_in[AW-1:0] == AW'(i)) begin
        mem_ff[i] <= wdata_in;
      end
    end
  end

  logic [BYTE_W-1:0] rd_q_ff [RD_PORTS];

  // read data stand one enabled cycle only, held while ce_in is low; old data on a same-cycle write
  for (genvar p = 0; p < RD_PORTS; p++) begin : g_rd
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        rd_q_ff[p] <= RDATA_IDLE;
      end else if (ce_in) begin
        if (re_in[p]) begin
          rd_q_ff[p] <= mem_ff[raddr_in[p*BYTE_W +: AW]];
        end else begin
          rd_q_ff[p] <= RDATA_IDLE;
        end
      end
    end
    assign rdata_out[p*BYTE_W +: BYTE_W] = rd_q_ff[p];
  end

endmodule
`default_nettype wire

// [hdl/cbr_stack.sv]
`timescale 1ns/10ps
`default_nettype none
module cbr_stack
  import cbr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic load_in,
  input wire logic [BYTE_W-1:0] load_d_in,
  output logic [BYTE_W-1:0] sp_out,
  output logic [BYTE_W-1:0] push_addr_out,
  output logic [BYTE_W-1:0] pop_addr_out
);

  logic [BYTE_W-1:0] sp_ff;
  logic [BYTE_W-1:0] nxt_sp;

  assign sp_out = sp_ff;
  assign push_addr_out = sp_ff + 8'h01;
  assign pop_addr_out = sp_ff;

  // push wins over pop, both over a software load
  always_comb begin
    nxt_sp = sp_ff;
    if (push_in) begin
      nxt_sp = sp_ff + 8'h01;
    end else if (pop_in) begin
      nxt_sp = sp_ff - 8'h01;
    end else if (load_in) begin
      nxt_sp = load_d_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sp_ff <= SP_RST;
    end else if (ce_in) begin
      sp_ff <= nxt_sp;
    end
  end

endmodule
`default_nettype wire

// [hdl/cbr_regs.sv]
// How it works
// - accumulator is 8 bits, loads results
// - eight byte working registers per bank
// - bank zero in use after reset
// - working reg k of bank n at 8n+k
// - banks share lowest 32 ram bytes
// - 8-bit aux operand for multiply, divide
// - 16-bit program counter resets to zero
// - counter advances by instruction length
// - counter changes only by step or control transfer
// - counter value never returned as data
// - two 16-bit data pointers, plain storage
// - pointer accesses use active pointer
// - pointer select register picks active pointer
// - stack pointer resets to 07h
// - push increments first, then writes
// - pop reads first, then decrements
// - calls, returns, interrupts move stack pointer
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module cbr_regs
  import cbr_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_DEPTH_DEF
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [BYTE_W-1:0] reg_addr_in,
  input wire logic [BYTE_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [BYTE_W-1:0] reg_rdata_out,
  input wire logic acc_ld_in,
  input wire logic [BYTE_W-1:0] acc_d_in,
  output logic [BYTE_W-1:0] acc_out,
  input wire logic aux_ld_in,
  input wire logic [BYTE_W-1:0] aux_d_in,
  output logic [BYTE_W-1:0] aux_out,
  input wire logic [WREG_W-1:0] wreg_idx_in,
  input wire logic wreg_wr_in,
  input wire logic wreg_rd_in,
  input wire logic [BYTE_W-1:0] wreg_d_in,
  output logic [BYTE_W-1:0] wreg_q_out,
  output logic [BANK_W-1:0] bank_sel_out,
  input wire logic pc_step_in,
  input wire logic [LEN_W-1:0] pc_len_in,
  input wire logic pc_jump_in,
  input wire logic [WORD_W-1:0] pc_target_in,
  output logic [WORD_W-1:0] program_counter_out,
  input wire logic dptr_ld_in,
  input wire logic [WORD_W-1:0] dptr_d_in,
  output logic [WORD_W-1:0] data_pointer_out,
  output logic pointer_select_out,
  input wire logic push_in,
  input wire logic [BYTE_W-1:0] push_d_in,
  input wire logic pop_in,
  output logic [BYTE_W-1:0] pop_q_out,
  output logic [BYTE_W-1:0] stack_pointer_out
);

  logic [BYTE_W-1:0] acc_ff;
  logic [BYTE_W-1:0] aux_ff;
  logic [BANK_W-1:0] bank_sel_ff;
  logic ptr_sel_ff;
  logic [WORD_W-1:0] pc_ff;
  logic [WORD_W-1:0] nxt_pc;
  logic [WORD_W-1:0] dptr_ff [2];
  logic [BYTE_W-1:0] reg_q_ff;
  logic [BYTE_W-1:0] nxt_reg_q;

  logic bus_wr_ram;
  logic bus_rd_ram;
  logic bus_wr_reg;
  logic wr_acc;
  logic wr_aux;
  logic wr_ptr_sel;
  logic wr_bank_sel;
  logic [1:0] wr_dp_lo;
  logic [1:0] wr_dp_hi;
  logic [BYTE_W-1:0] wreg_addr;

  logic ram_we;
  logic [BYTE_W-1:0] ram_waddr;
  logic [BYTE_W-1:0] ram_wdata;
  logic [RAM_RD_PORTS-1:0] ram_re;
  logic [RAM_RD_PORTS*BYTE_W-1:0] ram_raddr;
  logic [RAM_RD_PORTS*BYTE_W-1:0] ram_rdata;

  logic sp_load;
  logic [BYTE_W-1:0] push_addr;
  logic [BYTE_W-1:0] pop_addr;

  // the four working register banks need the low 32 bytes at least
  if (RAM_DEPTH < 32 || RAM_DEPTH > 256 ||
      (RAM_DEPTH & (RAM_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cbr_regs: RAM_DEPTH must be a power of two from 32 to 256");
  end

  // address decode of the register port
  assign bus_wr_ram = reg_wr_in && (reg_addr_in <= DIRECT_RAM_TOP);
  assign bus_rd_ram = reg_rd_in && (reg_addr_in <= DIRECT_RAM_TOP);
  assign bus_wr_reg = reg_wr_in && (reg_addr_in > DIRECT_RAM_TOP);

  // one select per register; an unmapped offset selects nothing, so the write is lost
  always_comb begin
    wr_acc = 1'b0;
    wr_aux = 1'b0;
    sp_load = 1'b0;
    wr_ptr_sel = 1'b0;
    wr_bank_sel = 1'b0;
    wr_dp_lo = 2'h0;
    wr_dp_hi = 2'h0;
    if (bus_wr_reg) begin
      case (reg_addr_in)
        OFS_ACC: begin
          wr_acc = 1'b1;
        end
        OFS_AUX: begin
          wr_aux = 1'b1;
        end
        OFS_SP: begin
          sp_load = 1'b1;
        end
        OFS_DP0_LO: begin
          wr_dp_lo = 2'h1;
        end
        OFS_DP0_HI: begin
          wr_dp_hi = 2'h1;
        end
        OFS_DP1_LO: begin
          wr_dp_lo = 2'h2;
        end
        OFS_DP1_HI: begin
          wr_dp_hi = 2'h2;
        end
        OFS_PTR_SEL: begin
          wr_ptr_sel = 1'b1;
        end
        OFS_BANK_SEL: begin
          wr_bank_sel = 1'b1;
        end
        default: begin
          wr_acc = 1'b0;
        end
      endcase
    end
  end

  // working register k of bank n lives at ram byte 8n+k
  assign wreg_addr = {3'h0, bank_sel_ff, wreg_idx_in};

  // accumulator: execution result wins over a port write
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_ff <= ACC_RST;
    end else if (ce_in) begin
      if (acc_ld_in) begin
        acc_ff <= acc_d_in;
      end else if (wr_acc) begin
        acc_ff <= reg_wdata_in;
      end
    end
  end

  // aux operand register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_ff <= AUX_RST;
    end else if (ce_in) begin
      if (aux_ld_in) begin
        aux_ff <= aux_d_in;
      end else if (wr_aux) begin
        aux_ff <= reg_wdata_in;
      end
    end
  end

  // bank select; a write here redirects working registers from the next cycle on
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bank_sel_ff <= BANK_RST;
    end else if (ce_in && wr_bank_sel) begin
      bank_sel_ff <= reg_wdata_in[BANK_LSB +: BANK_W];
    end
  end

  // pointer select
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ptr_sel_ff <= PTR_SEL_RST;
    end else if (ce_in && wr_ptr_sel) begin
      ptr_sel_ff <= reg_wdata_in[PTR_SEL_BIT];
    end
  end

  // data pointers; a full load targets the active one and wins over byte writes
  for (genvar i = 0; i < 2; i++) begin : g_dptr
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        dptr_ff[i] <= DPTR_RST;
      end else if (ce_in) begin
        if (dptr_ld_in && ptr_sel_ff == 1'(i)) begin
          dptr_ff[i] <= dptr_d_in;
        end else if (wr_dp_lo[i]) begin
          dptr_ff[i][7:0] <= reg_wdata_in;
        end else if (wr_dp_hi[i]) begin
          dptr_ff[i][15:8] <= reg_wdata_in;
        end
      end
    end
  end

  assign data_pointer_out = dptr_ff[ptr_sel_ff];

  // program counter: no port write reaches it, only jump or step
  always_comb begin
    nxt_pc = pc_ff;
    if (pc_jump_in) begin
      nxt_pc = pc_target_in;
    end else if (pc_step_in) begin
      nxt_pc = pc_ff + {14'h0000, pc_len_in};
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_ff <= PC_RST;
    end else if (ce_in) begin
      pc_ff <= nxt_pc;
    end
  end

  // stack pointer unit
  cbr_stack u_stack (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .push_in(push_in),
    .pop_in(pop_in),
    .load_in(sp_load),
    .load_d_in(reg_wdata_in),
    .sp_out(stack_pointer_out),
    .push_addr_out(push_addr),
    .pop_addr_out(pop_addr)
  );

  // one write port: push, then working register, then direct port write.
  // the execution logic never issues two at once; the order only settles misuse
  always_comb begin
    ram_we = 1'b0;
    ram_waddr = push_addr;
    ram_wdata = push_d_in;
    if (push_in) begin
      ram_we = 1'b1;
    end else if (wreg_wr_in) begin
      ram_we = 1'b1;
      ram_waddr = wreg_addr;
      ram_wdata = wreg_d_in;
    end else if (bus_wr_ram) begin
      ram_we = 1'b1;
      ram_waddr = reg_addr_in;
      ram_wdata = reg_wdata_in;
    end
  end

  always_comb begin
    ram_re = '0;
    ram_re[RP_BUS] = bus_rd_ram;
    ram_re[RP_WREG] = wreg_rd_in;
    ram_re[RP_POP] = pop_in;
    ram_raddr = '0;
    ram_raddr[RP_BUS*BYTE_W +: BYTE_W] = reg_addr_in;
    ram_raddr[RP_WREG*BYTE_W +: BYTE_W] = wreg_addr;
    ram_raddr[RP_POP*BYTE_W +: BYTE_W] = pop_addr;
  end

  cbr_iram #(
    .DEPTH(RAM_DEPTH),
    .RD_PORTS(RAM_RD_PORTS)
  ) u_iram (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .we_in(ram_we),
    .waddr_in(ram_waddr),
    .wdata_in(ram_wdata),
    .re_in(ram_re),
    .raddr_in(ram_raddr),
    .rdata_out(ram_rdata)
  );

  // register read mux; the program counter is deliberately absent
  always_comb begin
    nxt_reg_q = RDATA_IDLE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_ACC: begin
          nxt_reg_q = acc_ff;
        end
        OFS_AUX: begin
          nxt_reg_q = aux_ff;
        end
        OFS_SP: begin
          nxt_reg_q = stack_pointer_out;
        end
        OFS_DP0_LO: begin
          nxt_reg_q = dptr_ff[0][7:0];
        end
        OFS_DP0_HI: begin
          nxt_reg_q = dptr_ff[0][15:8];
        end
        OFS_DP1_LO: begin
          nxt_reg_q = dptr_ff[1][7:0];
        end
        OFS_DP1_HI: begin
          nxt_reg_q = dptr_ff[1][15:8];
        end
        OFS_PTR_SEL: begin
          nxt_reg_q = {7'h00, ptr_sel_ff};
        end
        OFS_BANK_SEL: begin
          nxt_reg_q = {6'h00, bank_sel_ff};
        end
        default: begin
          nxt_reg_q = RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_q_ff <= RDATA_IDLE;
    end else if (ce_in) begin
      reg_q_ff <= nxt_reg_q;
    end
  end

  // only one source is non-zero in any cycle, so an or merges them
  assign reg_rdata_out = reg_q_ff | ram_rdata[RP_BUS*BYTE_W +: BYTE_W];
  assign wreg_q_out = ram_rdata[RP_WREG*BYTE_W +: BYTE_W];
  assign pop_q_out = ram_rdata[RP_POP*BYTE_W +: BYTE_W];

  assign acc_out = acc_ff;
  assign aux_out = aux_ff;
  assign bank_sel_out = bank_sel_ff;
  assign pointer_select_out = ptr_sel_ff;
  assign program_counter_out = pc_ff; // fetch address only, never data

endmodule
`default_nettype wire

// [test/cbr_regs_props.sv]
`timescale 1ns/10ps
`default_nettype none
module cbr_regs_props (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic acc_ld_in,
  input wire logic [7:0] acc_d_in,
  input wire logic [7:0] acc_out,
  input wire logic [2:0] wreg_idx_in,
  input wire logic wreg_wr_in,
  input wire logic wreg_rd_in,
  input wire logic [7:0] wreg_d_in,
  input wire logic [7:0] wreg_q_out,
  input wire logic [1:0] bank_sel_out,
  input wire logic pc_step_in,
  input wire logic [1:0] pc_len_in,
  input wire logic pc_jump_in,
  input wire logic [15:0] pc_target_in,
  input wire logic [15:0] program_counter_out,
  input wire logic dptr_ld_in,
  input wire logic [15:0] dptr_d_in,
  input wire logic [15:0] data_pointer_out,
  input wire logic pointer_select_out,
  input wire logic push_in,
  input wire logic [7:0] push_d_in,
  input wire logic pop_in,
  input wire logic [7:0] pop_q_out,
  input wire logic [7:0] stack_pointer_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  acc_load_a: assert property (ce_in && acc_ld_in |=> acc_out == $past(acc_d_in))
    else $error("accumulator load wrong");
  pc_step_a: assert property (ce_in && pc_step_in && !pc_jump_in |=>
    program_counter_out == $past(program_counter_out) + 16'($past(pc_len_in)))
    else $error("counter step wrong");
  pc_hold_a: assert property (!(ce_in && (pc_step_in || pc_jump_in)) |=>
    $stable(program_counter_out))
    else $error("counter moved without transfer");
  pc_jump_a: assert property (ce_in && pc_jump_in |=>
    program_counter_out == $past(pc_target_in))
    else $error("counter jump wrong");
  push_sp_a: assert property (ce_in && push_in |=>
    stack_pointer_out == $past(stack_pointer_out) + 8'h01)
    else $error("push pointer wrong");
  pop_sp_a: assert property (ce_in && pop_in && !push_in |=>
    stack_pointer_out == $past(stack_pointer_out) - 8'h01)
    else $error("pop pointer wrong");
  push_pop_a: assert property (ce_in && push_in ##1 ce_in && pop_in && !push_in |=>
    pop_q_out == $past(push_d_in, 2))
    else $error("popped byte wrong");
  dptr_load_a: assert property (ce_in && dptr_ld_in ##1 $stable(pointer_select_out) |->
    data_pointer_out == $past(dptr_d_in))
    else $error("pointer load wrong");
  wreg_readback_a: assert property (ce_in && wreg_wr_in && !push_in ##1 ce_in &&
    wreg_rd_in && wreg_idx_in == $past(wreg_idx_in) && $stable(bank_sel_out) |=>
    wreg_q_out == $past(wreg_d_in, 2))
    else $error("working register readback wrong");
  cover property (ce_in && push_in ##1 ce_in && pop_in);
  cover property (ce_in && pc_jump_in);
  cover property (ce_in && dptr_ld_in && pointer_select_out == 1'b0);
endmodule
bind cbr_regs cbr_regs_props u_props (
  .clk_sys_in, .arst_n_in, .ce_in, .acc_ld_in, .acc_d_in, .acc_out,
  .wreg_idx_in, .wreg_wr_in, .wreg_rd_in, .wreg_d_in, .wreg_q_out, .bank_sel_out,
  .pc_step_in, .pc_len_in, .pc_jump_in, .pc_target_in, .program_counter_out,
  .dptr_ld_in, .dptr_d_in, .data_pointer_out, .pointer_select_out,
  .push_in, .push_d_in, .pop_in, .pop_q_out, .stack_pointer_out
);
`default_nettype wire

// [test/cbr_exec_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cbr_exec_model (
  input wire logic clk_sys_in,
  output logic [8:0] st_out,
  output logic [15:0] d_out,
  output logic [2:0] idx_out
);
  // strobes: acc, aux, wreg wr, wreg rd, step, jump, dptr, push, pop
  initial begin
    st_out = '0;
    d_out = '0;
    idx_out = '0;
  end
  task automatic ex(input int s, input logic [15:0] d, input logic [2:0] i);
    @(posedge clk_sys_in);
    st_out <= 9'h001 << s;
    d_out <= d;
    idx_out <= i;
  endtask
  // stale data would hide a late capture
  task automatic idle();
    @(posedge clk_sys_in);
    st_out <= '0;
    d_out <= ~d_out;
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cbr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, acc, aux, wq, popq, sp;
  logic [1:0] bank;
  logic [15:0] pc, dp, xd;
  logic psel;
  logic [8:0] st;
  logic [2:0] xi;
  int fail_count = 0;
  int compares = 0;
  always #10 clk = ~clk;
  cbr_exec_model u_exec (.clk_sys_in(clk), .st_out(st), .d_out(xd), .idx_out(xi));
  cbr_regs u_dut (
    .clk_sys_in(clk), .arst_n_in(rst_n), .ce_in(ce), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .acc_ld_in(st[0]), .acc_d_in(xd[7:0]), .acc_out(acc), .aux_ld_in(st[1]),
    .aux_d_in(xd[7:0]), .aux_out(aux), .wreg_idx_in(xi), .wreg_wr_in(st[2]),
    .wreg_rd_in(st[3]), .wreg_d_in(xd[7:0]), .wreg_q_out(wq), .bank_sel_out(bank),
    .pc_step_in(st[4]), .pc_len_in(xd[1:0]), .pc_jump_in(st[5]), .pc_target_in(xd),
    .program_counter_out(pc), .dptr_ld_in(st[6]), .dptr_d_in(xd),
    .data_pointer_out(dp), .pointer_select_out(psel), .push_in(st[7]),
    .push_d_in(xd[7:0]), .pop_in(st[8]), .pop_q_out(popq), .stack_pointer_out(sp)
  );
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("reg_rdata_out", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic run_op(input int s, input logic [15:0] d, input logic [2:0] i);
    u_exec.ex(s, d, i);
    u_exec.idle();
    #1;
  endtask
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("program_counter_out", PC_RST, pc);
    chk("bank_sel_out", 16'h0000, {14'h0000, bank});
    for (int k = 0; k < 10; k++) rd_reg(OFS_ACC + 8'(k), k == 2 ? SP_RST : 8'h00);
    for (int n = 0; n < 4; n++) begin
      // bank zero is left untouched so the reset default is what gets used
      if (n > 0) wr_reg(OFS_BANK_SEL, 8'(n));
      #1;
      chk("bank_sel_out", 16'(n), {14'h0000, bank});
      u_exec.ex(2, 16'(8'h40 + n), 3'h4);
      run_op(3, 16'h0000, 3'h4);
      chk("wreg_q_out", 16'(8'h40 + n), {8'h00, wq});
      rd_reg(8'(8 * n + 4), 8'(8'h40 + n));
      wr_reg(8'(8 * n + 7), 8'(8'h60 + n));
      run_op(3, 16'h0000, 3'h7);
      chk("wreg_q_out", 16'(8'h60 + n), {8'h00, wq});
    end
    run_op(7, 16'h00AA, 3'h0);
    chk("stack_pointer_out", 16'h0008, {8'h00, sp});
    rd_reg(8'h08, 8'hAA);
    u_exec.ex(7, 16'h0055, 3'h0);
    u_exec.ex(8, 16'h0000, 3'h0);
    u_exec.idle();
    #1;
    chk("pop_q_out", 16'h0055, {8'h00, popq});
    chk("stack_pointer_out", 16'h0008, {8'h00, sp});
    run_op(0, 16'h001E, 3'h0);
    rd_reg(OFS_ACC, 8'h1E);
    // a load while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    run_op(0, 16'h0077, 3'h0);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk("acc_out", 16'h001E, {8'h00, acc});
    run_op(1, 16'h0014, 3'h0);
    chk("aux_out", 16'h0014, {8'h00, aux});
    for (int l = 1; l < 4; l++) run_op(4, 16'(l), 3'h0);
    chk("program_counter_out", 16'h0006, pc);
    run_op(5, 16'h2430, 3'h0);
    wr_reg(8'h89, 8'hFF);
    rd_reg(8'h89, 8'h00);
    chk("program_counter_out", 16'h2430, pc);
    run_op(6, 16'h1516, 3'h0);
    wr_reg(OFS_PTR_SEL, 8'h01);
    wr_reg(OFS_DP1_LO, 8'h21);
    wr_reg(OFS_DP1_HI, 8'h20);
    #1;
    chk("data_pointer_out", 16'h2021, dp);
    chk("pointer_select_out", 16'h0001, {15'h0000, psel});
    wr_reg(OFS_PTR_SEL, 8'h00);
    #1;
    chk("data_pointer_out", 16'h1516, dp);
    chk("pointer_select_out", 16'h0000, {15'h0000, psel});
    rd_reg(OFS_DP0_HI, 8'h15);
    // a second reset in mid-run restores the power-up state
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("program_counter_out", PC_RST, pc);
    chk("stack_pointer_out", {8'h00, SP_RST}, {8'h00, sp});
    chk("bank_sel_out", 16'h0000, {14'h0000, bank});
    end_of_test();
  end
endmodule
`default_nettype wire
